// file: core/cfrc_top.sv
`timescale 1ns/1ps
`default_nettype none
module cfrc_top #(
	parameter int INT_CYCLES = cfrc_pkg::INT_PULSE_CYCLES
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic input_overvoltage,
	input wire logic input_undervoltage,
	input wire logic input_current_limit_event,
	input wire logic battery_undervoltage,
	input wire logic safety_timer_expired,
	input wire logic input_dynamic_power_management,
	input wire logic charge_complete,
	input wire logic below_recharge_threshold,
	input wire logic charge_enable,
	input wire logic system_rail_enable,
	input wire logic load_switch_rail_enable,
	input wire logic [2:0] thermistor_zone,
	output var logic [1:0] charge_state,
	output var logic int_n,
	output var logic power_good_output,
	output var logic input_overvoltage_status,
	output var logic input_undervoltage_status,
	output var logic battery_undervoltage_status,
	output var logic timer_fault_status,
	output var logic dynamic_power_management_status_bit,
	output var logic [2:0] thermistor_fault_field,
	output var logic charger_on,
	output var logic precharge_mode,
	output var logic input_current_clamp,
	output var logic input_current_reduce,
	output var logic [1:0] charge_current_shift,
	output var logic [7:0] battery_regulation_voltage_drop_mv,
	output var logic recharge_watch,
	output var logic system_rail_on,
	output var logic system_rail_from_battery,
	output var logic load_switch_rail_on,
	output var logic load_switch_rail_from_battery,
	output var logic thermistor_function_on
);
	typedef struct packed {
		logic [cfrc_pkg::IN_W-1:0] sync1;
		logic [cfrc_pkg::IN_W-1:0] sync2;
		logic [cfrc_pkg::IN_W-1:0] prev;
		logic [2:0] zone;
		logic [2:0] zone_prev;
		logic done;
		logic [1:0] state;
		logic pg;
		logic ov;
		logic uv;
		logic batuv;
		logic tmr;
		logic dpm;
		logic [2:0] tsf;
		logic chg;
		logic pre;
		logic clamp;
		logic reduce;
		logic [1:0] shift;
		logic [7:0] drop;
		logic sys_on;
		logic sys_bat;
		logic ls_on;
		logic ls_bat;
		logic ts_on;
		logic [cfrc_pkg::PULSE_CNT_W-1:0] since_trig;
	} cfrc_state_s;

	cfrc_state_s s_ff;
	cfrc_state_s nxt_s;
	logic [cfrc_pkg::IN_W-1:0] pins;
	logic [cfrc_pkg::IN_W-1:0] c;
	logic [2:0] ts;
	logic [2:0] zone_raw;
	logic vin_bad;
	logic vin_valid;
	logic cold_hot;
	logic any_fault;
	logic trig;
	logic pulse_n;

	assign pins = {thermistor_zone, load_switch_rail_enable, system_rail_enable, charge_enable,
		below_recharge_threshold, charge_complete, input_dynamic_power_management,
		safety_timer_expired, battery_undervoltage, input_current_limit_event,
		input_undervoltage, input_overvoltage};
	assign c = s_ff.sync2;
	assign zone_raw = c[cfrc_pkg::IN_TS_LO +: 3];
	// zone bits may settle on different edges, so a zone counts once seen on two edges
	assign ts = s_ff.zone;
	assign vin_bad = c[cfrc_pkg::IN_OV] | c[cfrc_pkg::IN_UV];
	assign vin_valid = !vin_bad;
	assign cold_hot = (ts == cfrc_pkg::TS_COLD) || (ts == cfrc_pkg::TS_HOT);
	assign any_fault = vin_bad | c[cfrc_pkg::IN_BATUV] | c[cfrc_pkg::IN_TMR]
		| c[cfrc_pkg::IN_DPM] | (ts != cfrc_pkg::TS_NORMAL);

	// any new condition except the recharge request, or a change into any non-normal zone, raises the interrupt
	always_comb
	begin
		trig = |(c[cfrc_pkg::IN_DONE:cfrc_pkg::IN_OV] & ~s_ff.prev[cfrc_pkg::IN_DONE:cfrc_pkg::IN_OV]);
		if ((ts != s_ff.zone_prev) && (ts != cfrc_pkg::TS_NORMAL))
			trig = 1'h1;
	end

	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.sync1 = pins;
		nxt_s.sync2 = s_ff.sync1;
		nxt_s.prev = c;
		nxt_s.zone = (zone_raw == s_ff.prev[cfrc_pkg::IN_TS_LO +: 3]) ? zone_raw : s_ff.zone;
		nxt_s.zone_prev = ts;
		// done holds until the battery sags below the recharge level, charging is withdrawn or the input goes bad;
		// a completion edge beats a recharge request in the same cycle
		nxt_s.done = ((c[cfrc_pkg::IN_DONE] & !s_ff.prev[cfrc_pkg::IN_DONE])
			| (s_ff.done & !c[cfrc_pkg::IN_RCHG]))
			& c[cfrc_pkg::IN_CHGEN] & vin_valid;
		if (any_fault)
			nxt_s.state = cfrc_pkg::ST_FAULT;
		else if (nxt_s.done)
			nxt_s.state = cfrc_pkg::ST_DONE;
		else if (c[cfrc_pkg::IN_ILIM] || c[cfrc_pkg::IN_CHGEN])
			nxt_s.state = cfrc_pkg::ST_PROGRESS;
		else
			nxt_s.state = cfrc_pkg::ST_READY;
		nxt_s.pg = vin_valid;
		nxt_s.ov = c[cfrc_pkg::IN_OV];
		nxt_s.uv = c[cfrc_pkg::IN_UV];
		nxt_s.batuv = c[cfrc_pkg::IN_BATUV];
		nxt_s.tmr = c[cfrc_pkg::IN_TMR];
		nxt_s.dpm = c[cfrc_pkg::IN_DPM];
		nxt_s.tsf = ts;
		nxt_s.chg = c[cfrc_pkg::IN_CHGEN] & vin_valid & !c[cfrc_pkg::IN_TMR]
			& !cold_hot & !nxt_s.done;
		nxt_s.pre = nxt_s.chg & c[cfrc_pkg::IN_BATUV];
		nxt_s.clamp = nxt_s.chg & c[cfrc_pkg::IN_ILIM];
		nxt_s.reduce = nxt_s.chg & c[cfrc_pkg::IN_DPM];
		nxt_s.shift = (ts == cfrc_pkg::TS_COOL) ? cfrc_pkg::CHARGE_CURRENT_SETTING_SHIFT_HALF
			: cfrc_pkg::CHARGE_CURRENT_SETTING_SHIFT_NONE;
		nxt_s.drop = (ts == cfrc_pkg::TS_WARM) ? cfrc_pkg::VREG_DROP_MV
			: cfrc_pkg::VREG_DROP_NONE;
		// battery undervoltage overrides the on-battery hold of a bad input
		if (c[cfrc_pkg::IN_BATUV])
		begin
			nxt_s.sys_on = c[cfrc_pkg::IN_SYSEN] & vin_valid;
			nxt_s.ls_on = c[cfrc_pkg::IN_LSEN] & vin_valid;
		end
		else
		begin
			nxt_s.sys_on = vin_bad | c[cfrc_pkg::IN_SYSEN];
			nxt_s.ls_on = vin_bad | c[cfrc_pkg::IN_LSEN];
		end
		nxt_s.sys_bat = vin_bad;
		nxt_s.ls_bat = vin_bad;
		nxt_s.ts_on = vin_valid & !c[cfrc_pkg::IN_TMR];
		if (trig)
			nxt_s.since_trig = cfrc_pkg::PULSE_CNT_W'(1);
		else if (s_ff.since_trig != '1)
			nxt_s.since_trig = s_ff.since_trig + 1'h1;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	cfrc_pulse #(
		.CYCLES(INT_CYCLES)
	) u_pulse (
		.mclk(mclk),
		.reset_n(reset_n),
		.trig(trig),
		.int_n(pulse_n)
	);

	assign charge_state = s_ff.state;
	assign int_n = pulse_n;
	assign power_good_output = s_ff.pg;
	assign input_overvoltage_status = s_ff.ov;
	assign input_undervoltage_status = s_ff.uv;
	assign battery_undervoltage_status = s_ff.batuv;
	assign timer_fault_status = s_ff.tmr;
	assign dynamic_power_management_status_bit = s_ff.dpm;
	assign thermistor_fault_field = s_ff.tsf;
	assign charger_on = s_ff.chg;
	assign precharge_mode = s_ff.pre;
	assign input_current_clamp = s_ff.clamp;
	assign input_current_reduce = s_ff.reduce;
	assign charge_current_shift = s_ff.shift;
	assign battery_regulation_voltage_drop_mv = s_ff.drop;
	assign recharge_watch = s_ff.done;
	assign system_rail_on = s_ff.sys_on;
	assign system_rail_from_battery = s_ff.sys_bat;
	assign load_switch_rail_on = s_ff.ls_on;
	assign load_switch_rail_from_battery = s_ff.ls_bat;
	assign thermistor_function_on = s_ff.ts_on;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	property p_ovp;
		c[cfrc_pkg::IN_OV] |=> charge_state == cfrc_pkg::ST_FAULT && !power_good_output
			&& !charger_on && !thermistor_function_on && system_rail_from_battery
			&& input_overvoltage_status;
	endproperty
	a_ovp: assert property (p_ovp) else $error("overvoltage response wrong");

	property p_uvp;
		c[cfrc_pkg::IN_UV] && !c[cfrc_pkg::IN_BATUV] |=> charge_state == cfrc_pkg::ST_FAULT
			&& !power_good_output && !charger_on && system_rail_on && load_switch_rail_on;
	endproperty
	a_uvp: assert property (p_uvp) else $error("undervoltage response wrong");

	property p_ilim;
		c[cfrc_pkg::IN_ILIM] && !any_fault && !nxt_s.done && c[cfrc_pkg::IN_CHGEN]
			|=> charge_state == cfrc_pkg::ST_PROGRESS && input_current_clamp && thermistor_function_on;
	endproperty
	a_ilim: assert property (p_ilim) else $error("current limit response wrong");

	property p_batuv;
		c[cfrc_pkg::IN_BATUV] |=> charge_state == cfrc_pkg::ST_FAULT
			&& (precharge_mode == charger_on) && (!system_rail_on || power_good_output);
	endproperty
	a_batuv: assert property (p_batuv) else $error("battery undervoltage response wrong");

	property p_timer;
		c[cfrc_pkg::IN_TMR] |=> timer_fault_status && !charger_on && !thermistor_function_on
			&& charge_state == cfrc_pkg::ST_FAULT;
	endproperty
	a_timer: assert property (p_timer) else $error("timer fault response wrong");

	property p_dpm;
		c[cfrc_pkg::IN_DPM] && nxt_s.chg |=> dynamic_power_management_status_bit
			&& input_current_reduce && charger_on && charge_state == cfrc_pkg::ST_FAULT;
	endproperty
	a_dpm: assert property (p_dpm) else $error("power management response wrong");

	property p_coldhot;
		cold_hot |=> !charger_on && thermistor_fault_field == $past(ts)
			&& charge_state == cfrc_pkg::ST_FAULT;
	endproperty
	a_coldhot: assert property (p_coldhot) else $error("cold or hot response wrong");

	property p_cool;
		ts == cfrc_pkg::TS_COOL |=> charge_current_shift == 2'h1
			&& thermistor_fault_field == 3'h2;
	endproperty
	a_cool: assert property (p_cool) else $error("cool response wrong");

	property p_warm;
		ts == cfrc_pkg::TS_WARM |=> battery_regulation_voltage_drop_mv == cfrc_pkg::VREG_DROP_MV;
	endproperty
	a_warm: assert property (p_warm) else $error("warm response wrong");

	property p_done;
		c[cfrc_pkg::IN_DONE] && !s_ff.prev[cfrc_pkg::IN_DONE] && c[cfrc_pkg::IN_CHGEN]
			&& !c[cfrc_pkg::IN_RCHG] && !any_fault
			|=> charge_state == cfrc_pkg::ST_DONE && !charger_on && recharge_watch && !int_n;
	endproperty
	a_done: assert property (p_done) else $error("charge done response wrong");

	property p_state_current;
		charge_state == cfrc_pkg::ST_DONE |-> !$past(any_fault) && $past(c[cfrc_pkg::IN_CHGEN]);
	endproperty
	a_state_current: assert property (p_state_current) else $error("stale done state");

	property p_pulse_len;
		$rose(int_n) |-> s_ff.since_trig == cfrc_pkg::PULSE_CNT_W'(INT_CYCLES + 1);
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("interrupt pulse length wrong");

	property p_pulse_start;
		trig |=> !int_n;
	endproperty
	a_pulse_start: assert property (p_pulse_start) else $error("interrupt did not start");

	property p_ov_ls;
		c[cfrc_pkg::IN_OV] && !c[cfrc_pkg::IN_BATUV] |=> load_switch_rail_on && load_switch_rail_from_battery;
	endproperty
	a_ov_ls: assert property (p_ov_ls) else $error("load switch not on battery");

	property p_watch_off;
		recharge_watch |-> !charger_on && power_good_output;
	endproperty
	a_watch_off: assert property (p_watch_off) else $error("charging while done");

	c_ovp: cover property (c[cfrc_pkg::IN_OV] ##1 !int_n);
	c_done: cover property (charge_state == cfrc_pkg::ST_DONE ##[1:20] charger_on);
	c_pulse: cover property ($rose(int_n));
	c_cool: cover property (charge_current_shift == cfrc_pkg::CHARGE_CURRENT_SETTING_SHIFT_HALF && charger_on);
	c_warm: cover property (battery_regulation_voltage_drop_mv == cfrc_pkg::VREG_DROP_MV && charger_on);
endmodule
`default_nettype wire

// file: core/cfrc_pkg.sv
`default_nettype none
package cfrc_pkg;
	// two-bit charge state encoding
	localparam logic [1:0] ST_READY = 2'h0;
	localparam logic [1:0] ST_PROGRESS = 2'h1;
	localparam logic [1:0] ST_DONE = 2'h2;
	localparam logic [1:0] ST_FAULT = 2'h3;
	// thermistor zone encoding, also used for the fault field
	localparam logic [2:0] TS_NORMAL = 3'h0;
	localparam logic [2:0] TS_COLD = 3'h1;
	localparam logic [2:0] TS_COOL = 3'h2;
	localparam logic [2:0] TS_WARM = 3'h3;
	localparam logic [2:0] TS_HOT = 3'h4;
	// bit positions in the synchronised input vector
	localparam int IN_OV = 0;
	localparam int IN_UV = 1;
	localparam int IN_ILIM = 2;
	localparam int IN_BATUV = 3;
	localparam int IN_TMR = 4;
	localparam int IN_DPM = 5;
	localparam int IN_DONE = 6;
	localparam int IN_RCHG = 7;
	localparam int IN_CHGEN = 8;
	localparam int IN_SYSEN = 9;
	localparam int IN_LSEN = 10;
	localparam int IN_TS_LO = 11;
	localparam int IN_W = 14;
	// warm-zone regulation drop and cool-zone current shift
	localparam logic [7:0] VREG_DROP_MV = 8'h8C;
	localparam logic [7:0] VREG_DROP_NONE = 8'h00;
	localparam logic [1:0] CHARGE_CURRENT_SETTING_SHIFT_HALF = 2'h1;
	localparam logic [1:0] CHARGE_CURRENT_SETTING_SHIFT_NONE = 2'h0;
	// interrupt pulse length
	localparam int INT_PULSE_US = 128;
	localparam int CLK_FREQ_MHZ = 100;
	localparam int INT_PULSE_CYCLES = INT_PULSE_US * CLK_FREQ_MHZ;
	localparam int PULSE_CNT_W = 16;
endpackage
`default_nettype wire

// file: core/cfrc_pulse.sv
`timescale 1ns/1ps
`default_nettype none
module cfrc_pulse #(
	parameter int CYCLES = cfrc_pkg::INT_PULSE_CYCLES
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic trig,
	output var logic int_n
);
	typedef struct packed {
		logic [cfrc_pkg::PULSE_CNT_W-1:0] cnt;
		logic int_n;
	} cfrc_pulse_s;

	cfrc_pulse_s s_ff;
	cfrc_pulse_s nxt_s;

	// a new event restarts the pulse rather than queueing a second one
	always_comb
	begin
		nxt_s = s_ff;
		if (trig)
		begin
			nxt_s.cnt = cfrc_pkg::PULSE_CNT_W'(CYCLES - 1);
			nxt_s.int_n = 1'h0;
		end
		else if (s_ff.cnt != '0)
			nxt_s.cnt = s_ff.cnt - 1'h1;
		else
			nxt_s.int_n = 1'h1;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_ff.cnt <= '0;
			s_ff.int_n <= 1'h1;
		end
		else
			s_ff <= nxt_s;
	end

	assign int_n = s_ff.int_n;
endmodule
`default_nettype wire

// file: verif/cfrc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfrc_host_model (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic int_n,
	output var int pulses,
	output var int last_len
);
	int run_ff;
	// width is only known once the line returns high, so it is logged then
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pulses <= 0;
			run_ff <= 0;
			last_len <= 0;
		end
		else if (!int_n)
			run_ff <= run_ff + 1;
		else if (run_ff != 0)
		begin
			pulses <= pulses + 1;
			last_len <= run_ff;
			run_ff <= 0;
		end
	end
endmodule
`default_nettype wire

// file: verif/test_charger_fault_response_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_charger_fault_response_control;
	localparam int INTC = 20;
	logic mclk;
	logic reset_n;
	logic [7:0] cnd;
	logic [2:0] en;
	logic [2:0] zone;
	wire logic [7:0] ctl;
	wire logic [7:0] stat;
	wire logic [1:0] st;
	wire logic [1:0] frm;
	wire logic [1:0] shf;
	wire logic [7:0] drop;
	wire logic int_n;
	wire logic watch;
	int pulses;
	int last_len;
	int bad_count = 0;
	int n_compared = 0;

	cfrc_top #(.INT_CYCLES(INTC)) DUT (.mclk, .reset_n, .input_overvoltage(cnd[0]),
		.input_undervoltage(cnd[1]), .input_current_limit_event(cnd[2]),
		.battery_undervoltage(cnd[3]), .safety_timer_expired(cnd[4]),
		.input_dynamic_power_management(cnd[5]), .charge_complete(cnd[6]),
		.below_recharge_threshold(cnd[7]), .charge_enable(en[0]), .system_rail_enable(en[1]),
		.load_switch_rail_enable(en[2]), .thermistor_zone(zone), .charge_state(st), .int_n,
		.power_good_output(ctl[2]), .input_overvoltage_status(stat[7]),
		.input_undervoltage_status(stat[6]), .battery_undervoltage_status(stat[5]),
		.timer_fault_status(stat[4]), .dynamic_power_management_status_bit(stat[3]),
		.thermistor_fault_field(stat[2:0]), .charger_on(ctl[7]), .precharge_mode(ctl[6]),
		.input_current_clamp(ctl[5]), .input_current_reduce(ctl[4]),
		.charge_current_shift(shf), .battery_regulation_voltage_drop_mv(drop),
		.recharge_watch(watch), .system_rail_on(ctl[1]), .system_rail_from_battery(frm[1]),
		.load_switch_rail_on(ctl[0]), .load_switch_rail_from_battery(frm[0]),
		.thermistor_function_on(ctl[3]));

	cfrc_host_model HOST (.mclk, .reset_n, .int_n, .pulses, .last_len);

	initial
	begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end

	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic idle;
		cnd = 8'h00;
		zone = cfrc_pkg::TS_NORMAL;
		en = 3'h7;
		step(35);
	endtask

	// applies a condition and expects exactly one notification of fixed width
	task automatic go(input logic [7:0] c, input logic [2:0] z);
		int p0;
		p0 = pulses;
		cnd = c;
		zone = z;
		step(35);
		chk(8'(pulses - p0), 8'h01);
		chk(8'(last_len), 8'(INTC));
	endtask

	task automatic fc(input logic [1:0] s, input logic [7:0] a, input logic [7:0] c);
		chk({6'h00, st}, {6'h00, s});
		chk(stat, a);
		chk(ctl, c);
	endtask

	task automatic t_vin;
		for (int i = 0; i < 2; i++)
		begin
			go(8'h01 << i, cfrc_pkg::TS_NORMAL);
			fc(cfrc_pkg::ST_FAULT, 8'h80 >> i, 8'h03);
			chk({6'h00, frm}, 8'h03);
			idle();
		end
		$display("test input faults finished");
	endtask

	task automatic t_ilim;
		go(8'h04, cfrc_pkg::TS_NORMAL);
		fc(cfrc_pkg::ST_PROGRESS, 8'h00, 8'hAF);
		chk({6'h00, frm}, 8'h00);
		idle();
		$display("test current limit finished");
	endtask

	task automatic t_batuv;
		go(8'h08, cfrc_pkg::TS_NORMAL);
		fc(cfrc_pkg::ST_FAULT, 8'h20, 8'hCF);
		// rail follows its enable while the input stays valid
		en = 3'h5;
		step(5);
		chk(ctl, 8'hCD);
		idle();
		$display("test battery low finished");
	endtask

	task automatic t_timer;
		go(8'h10, cfrc_pkg::TS_NORMAL);
		fc(cfrc_pkg::ST_FAULT, 8'h10, 8'h07);
		idle();
		$display("test timer finished");
	endtask

	task automatic t_dpm;
		go(8'h20, cfrc_pkg::TS_NORMAL);
		fc(cfrc_pkg::ST_FAULT, 8'h08, 8'h9F);
		idle();
		$display("test power management finished");
	endtask

	task automatic t_zone;
		logic [2:0] zl [4];
		zl = '{cfrc_pkg::TS_COLD, cfrc_pkg::TS_HOT, cfrc_pkg::TS_COOL, cfrc_pkg::TS_WARM};
		foreach (zl[i])
		begin
			go(8'h00, zl[i]);
			fc(cfrc_pkg::ST_FAULT, {5'h00, zl[i]}, i < 2 ? 8'h0F : 8'h8F);
			chk({6'h00, shf}, i == 2 ? 8'h01 : 8'h00);
			chk(drop, i == 3 ? cfrc_pkg::VREG_DROP_MV : 8'h00);
			idle();
		end
		$display("test thermistor finished");
	endtask

	task automatic t_done;
		go(8'h40, cfrc_pkg::TS_NORMAL);
		fc(cfrc_pkg::ST_DONE, 8'h00, 8'h0F);
		chk({7'h00, watch}, 8'h01);
		cnd = 8'hC0;
		step(5);
		chk({7'h00, watch}, 8'h00);
		chk({6'h00, st}, {6'h00, cfrc_pkg::ST_PROGRESS});
		idle();
		$display("test charge done finished");
	endtask

	task automatic t_ready;
		en = 3'h6;
		step(5);
		chk({6'h00, st}, {6'h00, cfrc_pkg::ST_READY});
		idle();
		$display("test ready finished");
	endtask

	initial
	begin
		reset_n = 1'h0;
		cnd = 8'h00;
		en = 3'h0;
		zone = cfrc_pkg::TS_NORMAL;
		step(10);
		reset_n = 1'h1;
		idle();
		t_vin();
		t_ilim();
		t_batuv();
		t_timer();
		t_dpm();
		t_zone();
		t_done();
		t_ready();
		conclude();
	end
endmodule
`default_nettype wire
